/* tmr3_defs.svh */
/*
 Register offsets, field positions, reset values and counts of the capture/compare timer.
 Assumes inclusion by the design modules (edge detector and top); definitions only.
*/
`ifndef TMR3_DEFS_SVH
`define TMR3_DEFS_SVH

`define TMR3_OFF_CTRL 12'h000
`define TMR3_OFF_MODE 12'h004
`define TMR3_OFF_COUNT 12'h008
`define TMR3_OFF_CC0 12'h00c
`define TMR3_OFF_CC1 12'h010
`define TMR3_OFF_STAT 12'h014
`define TMR3_OFF_CLR 12'h018
`define TMR3_OFF_IEN 12'h01c
`define TMR3_OFF_EDGE 12'h020

// Control register fields
`define TMR3_CTRL_CE 0
`define TMR3_CTRL_BASE 1
`define TMR3_CTRL_PS_LO 4
`define TMR3_CTRL_PS_HI 6

// Mode register fields
`define TMR3_MODE_ETI 0
`define TMR3_MODE_CLEAR_ON_MATCH_ENABLE 1
`define TMR3_MODE_OST 2
`define TMR3_MODE_CMS0 3
`define TMR3_MODE_CMS1 4
`define TMR3_MODE_OUTEN 5

// Status, clear and enable share one layout
`define TMR3_ST_OVF 0
`define TMR3_ST_CC0 1
`define TMR3_ST_CC1 2

`define TMR3_CTRL_RST 8'h00
`define TMR3_MODE_RST 8'h00
`define TMR3_EDGE_RST 6'h00
`define TMR3_CNT_MAX 16'hffff
`define TMR3_SYNC_STAGES 3

`endif

/* tmr3_pkg.sv */
/*
 Types shared by the capture/compare timer.
 Assumes tmr3_defs.svh is on the include path.
*/
package tmr3_pkg;
	typedef enum logic [1:0] {
		TMR3_EDGE_NONE,
		TMR3_EDGE_RISE,
		TMR3_EDGE_FALL,
		TMR3_EDGE_BOTH
	} tmr3_edge_t;
endpackage

/* tmr3_edge_det.sv */
/*
 Edge detector for one pin: three-stage synchroniser, then a selectable edge pulse.
 Assumes the pin is asynchronous to clock_i; a change counts when stages two and three agree.
*/
`include "tmr3_defs.svh"
module tmr3_edge_det
	import tmr3_pkg::*;
(
	input wire logic clock_i,
	input wire logic rst_i,
	input wire logic pin_i,
	input wire tmr3_edge_t edge_sel_i,
	output logic pulse_o
);
	logic [`TMR3_SYNC_STAGES-1:0] sync;
	logic level;
	logic rise;
	logic fall;

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			sync <= '0;
		end else begin
			sync <= {sync[1:0], pin_i};
		end
	end

	// Stage 0 is only read by stage 1; the filtered level moves when 1 and 2 agree
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			level <= 1'b0;
		end else if (sync[1] == sync[2]) begin
			level <= sync[2];
		end
	end

	assign rise = (sync[1] == sync[2]) && sync[2] && !level;
	assign fall = (sync[1] == sync[2]) && !sync[2] && level;

	always_comb begin
		unique case (edge_sel_i)
			TMR3_EDGE_NONE: pulse_o = 1'b0;
			TMR3_EDGE_RISE: pulse_o = rise;
			TMR3_EDGE_FALL: pulse_o = fall;
			TMR3_EDGE_BOTH: pulse_o = rise | fall;
		endcase
	end
endmodule

/* tmr3_top.sv */
/*
 16-bit up counter with two capture/compare registers, overflow and match
 interrupts, clear on match and one set/reset pulse output, behind an APB slave.
 Assumes a single clock; trigger and external clock pins are asynchronous.
*/
// Local design decisions: the register addresses and register access over APB.
// Contract
// R1 - One 16-bit counter with exactly two capture/compare registers.
// R2 - Software selects base clock: system clock or system clock divided by two.
// R3 - Prescaler ratios 1/2 through 1/256 derive the internal count clock.
// R4 - Count source is external pulses or the prescaled internal clock.
// R5 - Capture mode: valid trigger edge raises that channel's interrupt.
// R6 - Compare mode: counter equal to register raises that channel's interrupt.
// R7 - Counter overflow raises a dedicated overflow interrupt.
// R8 - Software selects free running or stop after overflow.
// R9 - Counter clears to zero on compare match when clearing is enabled.
// R10 - Exactly one external pulse output driven by compare logic.
// R11 - Count enable starts counting; clearing it stops and zeroes the counter.
// R12 - Clear on match uses register zero only, never register one.
// R13 - Pulse output set by match zero, reset by match one.
// R14 - External clock select counts synchronised valid external edges.
// R15 - Increment by one per count tick, wrap at maximum and flag overflow.
// R16 - Capture latches the counter on each trigger and holds it.
`include "tmr3_defs.svh"
module tmr3_top
	import tmr3_pkg::*;
(
	input wire logic clock_i,
	input wire logic rst_i,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic capture_trigger_input_0_i,
	input wire logic capture_trigger_input_1_i,
	input wire logic ext_count_clock_i,
	output logic pulse_output_pin_o,
	output logic irq_o
);
	logic [7:0] ctrl;
	logic [7:0] mode;
	logic [5:0] edge_cfg;
	logic [15:0] main_up_counter;
	logic [15:0] capcmp_reg_zero;
	logic [15:0] capcmp_reg_one;
	logic [2:0] irq_status;
	logic [2:0] irq_enable;
	logic [8:0] prescale;
	logic base_tick;
	logic stopped;
	logic wr_en;
	logic rd_en;
	logic count_enable_bit;
	logic external_clock_select;
	logic clear_on_match_enable;
	logic ovf_stop_mode;
	logic cms0;
	logic cms1;
	logic [2:0] ps_sel;
	logic int_tick;
	logic ext_tick;
	logic count_tick;
	logic trig0;
	logic trig1;
	logic ext_edge;
	logic match0;
	logic match1;
	logic wrap;
	logic counter_overflow_irq;
	logic [1:0] capcmp_channel_irq;
	logic [2:0] events;
	logic [2:0] clr_req;
	logic [15:0] next_counter;

	assign count_enable_bit = ctrl[`TMR3_CTRL_CE];
	assign ps_sel = ctrl[`TMR3_CTRL_PS_HI:`TMR3_CTRL_PS_LO];
	assign external_clock_select = mode[`TMR3_MODE_ETI];
	assign clear_on_match_enable = mode[`TMR3_MODE_CLEAR_ON_MATCH_ENABLE];
	assign ovf_stop_mode = mode[`TMR3_MODE_OST];
	assign cms0 = mode[`TMR3_MODE_CMS0];
	assign cms1 = mode[`TMR3_MODE_CMS1];

	// APB: zero wait states, unmapped addresses answer with an error
	assign pready = 1'b1;
	assign wr_en = psel && penable && pwrite;
	assign rd_en = psel && penable && !pwrite;

	always_comb begin
		pslverr = 1'b0;
		if (psel && penable) begin
			unique case (paddr)
				`TMR3_OFF_CTRL, `TMR3_OFF_MODE, `TMR3_OFF_COUNT, `TMR3_OFF_CC0,
				`TMR3_OFF_CC1, `TMR3_OFF_STAT, `TMR3_OFF_CLR, `TMR3_OFF_IEN,
				`TMR3_OFF_EDGE: pslverr = 1'b0;
				default: pslverr = 1'b1;
			endcase
		end
	end

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			prdata <= 32'h0000_0000;
		end else if (psel && !penable && !pwrite) begin
			unique case (paddr)
				`TMR3_OFF_CTRL: prdata <= {24'h00_0000, ctrl};
				`TMR3_OFF_MODE: prdata <= {24'h00_0000, mode};
				`TMR3_OFF_COUNT: prdata <= {16'h0000, main_up_counter};
				`TMR3_OFF_CC0: prdata <= {16'h0000, capcmp_reg_zero};
				`TMR3_OFF_CC1: prdata <= {16'h0000, capcmp_reg_one};
				`TMR3_OFF_STAT: prdata <= {29'h0000_0000, irq_status};
				`TMR3_OFF_IEN: prdata <= {29'h0000_0000, irq_enable};
				`TMR3_OFF_EDGE: prdata <= {26'h000_0000, edge_cfg};
				default: prdata <= 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			ctrl <= `TMR3_CTRL_RST;
			mode <= `TMR3_MODE_RST;
			edge_cfg <= `TMR3_EDGE_RST;
			irq_enable <= 3'h0;
		end else if (wr_en) begin
			if (paddr == `TMR3_OFF_CTRL) begin
				ctrl <= pwdata[7:0];
			end
			if (paddr == `TMR3_OFF_MODE) begin
				mode <= pwdata[7:0];
			end
			if (paddr == `TMR3_OFF_EDGE) begin
				edge_cfg <= pwdata[5:0];
			end
			if (paddr == `TMR3_OFF_IEN) begin
				irq_enable <= pwdata[2:0];
			end
		end
	end

	// Base clock: every cycle, or every second cycle when the halved clock is chosen
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			base_tick <= 1'b0;
		end else begin
			base_tick <= ctrl[`TMR3_CTRL_BASE] ? !base_tick : 1'b1; // see R2
		end
	end

	// Prescaler runs only while counting so the first tick lands a full period late
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			prescale <= 9'h000;
		end else if (!count_enable_bit) begin
			prescale <= 9'h000;
		end else if (base_tick) begin
			prescale <= prescale + 9'h001;
		end
	end

	// Ratio 1/2^(sel+1): tick when the low sel+1 bits roll over
	always_comb begin
		int_tick = 1'b0;
		if (base_tick && count_enable_bit) begin
			int_tick = (prescale[ps_sel] == 1'b1) &&
				((prescale & ((9'h001 << ps_sel) - 9'h001)) == ((9'h001 << ps_sel) - 9'h001)); // see R3
		end
	end

	tmr3_edge_det u_edge_trig0 (
		.clock_i(clock_i),
		.rst_i(rst_i),
		.pin_i(capture_trigger_input_0_i),
		.edge_sel_i(tmr3_edge_t'(edge_cfg[1:0])),
		.pulse_o(trig0)
	);

	tmr3_edge_det u_edge_trig1 (
		.clock_i(clock_i),
		.rst_i(rst_i),
		.pin_i(capture_trigger_input_1_i),
		.edge_sel_i(tmr3_edge_t'(edge_cfg[3:2])),
		.pulse_o(trig1)
	);

	tmr3_edge_det u_edge_extclk (
		.clock_i(clock_i),
		.rst_i(rst_i),
		.pin_i(ext_count_clock_i),
		.edge_sel_i(tmr3_edge_t'(edge_cfg[5:4])),
		.pulse_o(ext_edge)
	);

	assign ext_tick = ext_edge && count_enable_bit; // see R14
	assign count_tick = (external_clock_select ? ext_tick : int_tick) && !stopped; // see R4
	assign match0 = cms0 && count_enable_bit && (main_up_counter == capcmp_reg_zero);
	assign match1 = cms1 && count_enable_bit && (main_up_counter == capcmp_reg_one);
	assign wrap = count_tick && (main_up_counter == `TMR3_CNT_MAX);

	// Counter: one per tick, wraps at maximum, zeroed by enable low or match zero
	always_comb begin
		next_counter = main_up_counter;
		if (!count_enable_bit) begin
			next_counter = 16'h0000; // see R11
		end else if (count_tick) begin
			if (match0 && clear_on_match_enable) begin
				next_counter = 16'h0000; // see R9, R12
			end else begin
				next_counter = main_up_counter + 16'h0001; // see R1, R15
			end
		end
	end

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			main_up_counter <= 16'h0000;
		end else begin
			main_up_counter <= next_counter;
		end
	end

	// Overflow stop holds the count at zero until the enable is cycled
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			stopped <= 1'b0;
		end else if (!count_enable_bit) begin
			stopped <= 1'b0;
		end else if (wrap && ovf_stop_mode) begin
			stopped <= 1'b1; // see R8
		end
	end

	// Capture in capture mode, software write only in compare mode
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			capcmp_reg_zero <= 16'h0000;
		end else if (!cms0 && trig0 && count_enable_bit) begin
			capcmp_reg_zero <= main_up_counter; // see R16
		end else if (cms0 && wr_en && paddr == `TMR3_OFF_CC0) begin
			capcmp_reg_zero <= pwdata[15:0];
		end
	end

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			capcmp_reg_one <= 16'h0000;
		end else if (!cms1 && trig1 && count_enable_bit) begin
			capcmp_reg_one <= main_up_counter; // see R16
		end else if (cms1 && wr_en && paddr == `TMR3_OFF_CC1) begin
			capcmp_reg_one <= pwdata[15:0];
		end
	end

	// Match events fire once, on the tick that leaves the matching value
	assign capcmp_channel_irq[0] = cms0 ? (match0 && count_tick) :
		(trig0 && count_enable_bit); // see R5, R6
	assign capcmp_channel_irq[1] = cms1 ? (match1 && count_tick) :
		(trig1 && count_enable_bit); // see R5, R6
	assign counter_overflow_irq = wrap; // see R7

	// Set/reset output: match zero sets, match one resets; set wins a tie
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			pulse_output_pin_o <= 1'b0;
		end else if (!mode[`TMR3_MODE_OUTEN]) begin
			pulse_output_pin_o <= 1'b0;
		end else if (match0 && count_tick) begin
			pulse_output_pin_o <= 1'b1; // see R10, R13
		end else if (match1 && count_tick) begin
			pulse_output_pin_o <= 1'b0; // see R13
		end
	end

	// Sticky status; a new event wins over a clear in the same cycle
	assign events = {capcmp_channel_irq, counter_overflow_irq};
	assign clr_req = (wr_en && paddr == `TMR3_OFF_CLR) ? pwdata[2:0] : 3'h0;

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			irq_status <= 3'h0;
		end else begin
			irq_status <= (irq_status & ~clr_req) | events;
		end
	end

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			irq_o <= 1'b0;
		end else begin
			irq_o <= |(((irq_status & ~clr_req) | events) & irq_enable);
		end
	end
endmodule

/* tmr3_props.sv */
/* Port checker for the capture/compare timer.
 Assumes bind into tmr3_top; shadows control writes seen on APB. */
module tmr3_chk(
	input wire logic clock_i,
	input wire logic rst_i,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic capture_trigger_input_0_i,
	input wire logic capture_trigger_input_1_i,
	input wire logic ext_count_clock_i,
	input wire logic pulse_output_pin_o,
	input wire logic irq_o
);
	logic ce;
	logic oe;
	logic [2:0] ien;
	wire wr = psel && penable && pwrite;
	wire rd = psel && penable && !pwrite;
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			ce <= 1'b0;
			oe <= 1'b0;
			ien <= 3'h0;
		end else if (wr) begin
			if (paddr == 12'h000) ce <= pwdata[0];
			if (paddr == 12'h004) oe <= pwdata[5];
			if (paddr == 12'h01c) ien <= pwdata[2:0];
		end
	end
	default clocking @(posedge clock_i); endclocking
	default disable iff (rst_i);
	chk_ready_now: assert property (psel |-> pready) else $error("pready low");
	chk_bad_addr: assert property (psel && penable && paddr > 12'h020 |-> pslverr)
		else $error("no error on unmapped address");
	chk_good_addr: assert property (psel && penable && paddr <= 12'h020 && paddr[1:0] == 2'h0
		|-> !pslverr) else $error("error on mapped address");
	chk_upper_zero: assert property (rd |-> prdata[31:16] == 16'h0) else $error("upper bits set");
	chk_clr_zero: assert property (rd && paddr == 12'h018 |-> prdata == 32'h0)
		else $error("clear register read nonzero");
	chk_stat_width: assert property (rd && paddr == 12'h014 |-> prdata[31:3] == 29'h0)
		else $error("status bits out of range");
	chk_out_off: assert property ((!oe)[*3] |-> !pulse_output_pin_o)
		else $error("output pin high while disabled");
	chk_irq_gate: assert property ((ien == 3'h0)[*3] |-> !irq_o)
		else $error("interrupt with all sources masked");
	chk_idle_count: assert property (
		(!ce)[*4] ##0 (rd && paddr == 12'h008) |-> prdata == 32'h0)
		else $error("counter nonzero while stopped");
endmodule
bind tmr3_top tmr3_chk u_chk(.clock_i, .rst_i, .psel, .penable, .pwrite, .paddr, .pwdata,
	.prdata, .pready, .pslverr, .capture_trigger_input_0_i, .capture_trigger_input_1_i,
	.ext_count_clock_i, .pulse_output_pin_o, .irq_o);

/* tmr3_pins.sv */
/* Far-side pins: two trigger sources and an external count source.
 Assumes cmd_i pulses for one cycle; each pulse makes one edge. */
module tmr3_pins(
	input wire logic clock_i,
	input wire logic rst_i,
	input wire logic [2:0] cmd_i,
	output logic trig0_o,
	output logic trig1_o,
	output logic ext_o
);
	timeunit 1ns;
	timeprecision 1ps;
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			{ext_o, trig1_o, trig0_o} <= 3'h0;
		end else begin
			{ext_o, trig1_o, trig0_o} <= {ext_o, trig1_o, trig0_o} ^ cmd_i;
		end
	end
endmodule

/* tmr3_top_tb.sv */
/* Self-checking bench for the capture/compare timer.
 Assumes zero-wait APB slave and pins driven by tmr3_pins. */
module tmr3_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clock_i = 1'b0;
	logic rst_i = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h0;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, d, c1, c2;
	logic pready, pslverr, e, t0, t1, ext, pin, irq;
	logic [1:0] seen;
	logic [2:0] cmd = 3'h0;
	int n_errors = 0;
	int compares = 0;
	int cyc = 0;
	always #2 clock_i = ~clock_i;
	tmr3_top i_dut(.clock_i, .rst_i, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .capture_trigger_input_0_i(t0), .capture_trigger_input_1_i(t1),
		.ext_count_clock_i(ext), .pulse_output_pin_o(pin), .irq_o(irq));
	tmr3_pins i_pins(.clock_i, .rst_i, .cmd_i(cmd), .trig0_o(t0), .trig1_o(t1), .ext_o(ext));
	task summarize;
		$display("errors %0d compares %0d", n_errors, compares);
		if (n_errors == 0 && compares > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	task chk(input logic [31:0] s, input logic [31:0] x);
		compares++;
		if (s !== x) begin
			n_errors++;
			$display("unexpected at %0t: seen %h expected %h", $time, s, x);
		end
	endtask
	task xf(input logic w, input logic [11:0] a, input logic [31:0] wd);
		@(posedge clock_i);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge clock_i);
		penable <= 1'b1;
		do @(posedge clock_i); while (pready !== 1'b1);
		d = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task flip(input int k);
		@(posedge clock_i);
		cmd <= 3'h1 << k;
		@(posedge clock_i);
		cmd <= 3'h0;
		repeat (10) @(posedge clock_i);
	endtask
	task t_regs;
		int a;
		for (a = 0; a <= 32; a += 4) begin
			xf(1'b0, a[11:0], 32'h0);
			chk(d, 32'h0);
			chk(e, 32'h0);
		end
		xf(1'b1, 12'h040, 32'hff);
		chk(e, 32'h1);
		xf(1'b0, 12'h040, 32'h0);
		chk(d, 32'h0);
		xf(1'b1, 12'h01c, 32'hffffffff);
		xf(1'b0, 12'h01c, 32'h0);
		chk(d, 32'h7);
		xf(1'b1, 12'h01c, 32'h0);
		$display("registers done");
	endtask
	task t_count;
		int s, b, p;
		for (b = 0; b < 2; b++) begin
			for (s = 0; s < 8; s++) begin
				p = (2 << s) << b;
				xf(1'b1, 12'h000, 32'h0);
				xf(1'b0, 12'h008, 32'h0);
				chk(d, 32'h0);
				xf(1'b1, 12'h000, {25'h0, s[2:0], 2'h0, b[0], 1'b1});
				xf(1'b0, 12'h008, 32'h0);
				c1 = d;
				repeat (4 * p - 3) @(posedge clock_i);
				xf(1'b0, 12'h008, 32'h0);
				chk(d - c1, 32'h4);
			end
		end
		xf(1'b1, 12'h000, 32'h0);
		$display("prescaler done");
	endtask
	task t_cmp;
		int i, mx;
		xf(1'b1, 12'h004, 32'h3a);
		xf(1'b1, 12'h00c, 32'h14);
		xf(1'b1, 12'h010, 32'ha);
		xf(1'b1, 12'h01c, 32'h6);
		xf(1'b1, 12'h000, 32'h1);
		mx = 0;
		seen = 2'h0;
		for (i = 0; i < 30; i++) begin
			xf(1'b0, 12'h008, 32'h0);
			if (d > mx) mx = d;
			seen = seen | {pin, !pin};
			// After the first clear the pin is high from zero up to register one, low above it
			if (i >= 15 && d > 0 && d < 10) chk(pin, 32'h1);
			if (i >= 15 && d > 11 && d < 20) chk(pin, 32'h0);
		end
		chk(mx > 18 && mx < 21, 32'h1);
		chk(seen, 32'h3);
		xf(1'b0, 12'h014, 32'h0);
		chk(d, 32'h6);
		chk(irq, 32'h1);
		xf(1'b1, 12'h01c, 32'h0);
		repeat (3) @(posedge clock_i);
		chk(irq, 32'h0);
		xf(1'b1, 12'h000, 32'h0);
		xf(1'b1, 12'h018, 32'h6);
		xf(1'b0, 12'h014, 32'h0);
		chk(d, 32'h0);
		$display("compare done");
	endtask
	task t_cap;
		int k;
		xf(1'b1, 12'h004, 32'h0);
		xf(1'b1, 12'h020, 32'h9);
		xf(1'b1, 12'h01c, 32'h6);
		xf(1'b1, 12'h000, 32'h1);
		repeat (20) @(posedge clock_i);
		xf(1'b0, 12'h008, 32'h0);
		c1 = d;
		flip(0);
		xf(1'b0, 12'h008, 32'h0);
		c2 = d;
		xf(1'b0, 12'h00c, 32'h0);
		chk(d >= c1 && d <= c2, 32'h1);
		c1 = d;
		xf(1'b1, 12'h00c, 32'h1234);
		flip(1);
		xf(1'b0, 12'h00c, 32'h0);
		chk(d, c1);
		xf(1'b0, 12'h014, 32'h0);
		chk(d, 32'h2);
		chk(irq, 32'h1);
		flip(1);
		xf(1'b0, 12'h014, 32'h0);
		chk(d, 32'h6);
		xf(1'b1, 12'h018, 32'h7);
		xf(1'b1, 12'h000, 32'h0);
		for (k = 0; k < 4; k++) begin
			xf(1'b1, 12'h004, 32'h1);
			xf(1'b1, 12'h020, k << 4);
			xf(1'b1, 12'h000, 32'h1);
			repeat (4) flip(2);
			xf(1'b0, 12'h008, 32'h0);
			chk(d, (k == 0) ? 32'h0 : (k == 3) ? 32'h4 : 32'h2);
			xf(1'b1, 12'h000, 32'h0);
		end
		$display("capture done");
	endtask
	always @(posedge clock_i) begin
		cyc++;
		if (cyc > 30000) begin
			n_errors++;
			summarize;
		end
	end
	initial begin
		repeat (2) @(posedge clock_i);
		rst_i <= 1'b0;
		t_regs;
		t_count;
		t_cmp;
		t_cap;
		summarize;
	end
endmodule
